/* core/bcd_compare_add_sub_unit.sv */
/*
  BCD datapath: block range compare, clear carry, add and subtract,
  with carry, zero and error flags held here.
  Assumes the scan engine drives operands, table and fault on i_clk_sys.
*/
`timescale 1ns/1ps
module bcd_compare_add_sub_unit (
  // Clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rstn,
  // Operation request
  input  wire logic                      i_exec_cond,
  input  wire bcd_alu_pkg::op_req_t      i_req,
  input  wire logic                      i_indirect_fault,
  // Range table, word 0 is the base word
  input  wire bcd_alu_pkg::range_table_t i_range_table,
  // Results
  output logic [bcd_alu_pkg::WORD_W-1:0] o_result,
  output bcd_alu_pkg::flags_t            o_flags,
  output logic                           o_busy,
  output logic                           o_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bcd_alu_pkg::state_t               state_q;
  logic [bcd_alu_pkg::K_W-1:0]       k_q;
  logic [bcd_alu_pkg::WORD_W-1:0]    acc_q;
  logic                              cmp_err_q;
  logic [bcd_alu_pkg::WORD_W-1:0]    result_q;
  bcd_alu_pkg::flags_t               flags_q;
  logic                              busy_q;
  logic                              done_q;

  logic                              exec_idle;
  logic                              is_sub;
  logic                              adder_cin;
  logic [bcd_alu_pkg::WORD_W-1:0]    sum;
  logic                              sum_cout;
  logic                              arith_err;
  logic [3:0]                        n_live;
  logic [3:0]                        last_k;
  logic [bcd_alu_pkg::IDX_W-1:0]     lo_idx;
  logic [bcd_alu_pkg::IDX_W-1:0]     hi_idx;
  logic [bcd_alu_pkg::WORD_W-1:0]    lo_lim;
  logic [bcd_alu_pkg::WORD_W-1:0]    hi_lim;
  logic [bcd_alu_pkg::WORD_W-1:0]    cd;
  logic                              hit;
  logic                              cmp_last;
  logic [bcd_alu_pkg::WORD_W-1:0]    acc_d;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic path
  // An operation executes only in idle with its condition on
  assign exec_idle = i_exec_cond && (state_q == bcd_alu_pkg::ST_IDLE);
  assign is_sub    = i_req.op == bcd_alu_pkg::OP_SUB;
  // Subtract is 10000 + a - b - cy: nines complement plus inverted carry
  assign adder_cin = is_sub ? ~flags_q.carry : flags_q.carry;
  assign arith_err = !bcd_alu_pkg::bcd_ok(i_req.word_a)
                  || !bcd_alu_pkg::bcd_ok(i_req.word_b)
                  || i_indirect_fault;

  bcd_word_adder #(
    .DIGITS (bcd_alu_pkg::DIGITS)
  ) u_adder (
    .i_a    (i_req.word_a),
    .i_b    (i_req.word_b),
    .i_sub  (is_sub),
    .i_cin  (adder_cin),
    .o_sum  (sum),
    .o_cout (sum_cout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare path, reading the live table every cycle
  assign n_live = i_range_table[0][bcd_alu_pkg::SIZE_DIGIT_LSB +: 4];
  assign last_k = (n_live > bcd_alu_pkg::MAX_N_DIGIT) ? bcd_alu_pkg::MAX_N_DIGIT
                                                       : n_live;
  // Range k sits in words 2k+1 (lower) and 2k+2 (upper)
  assign lo_idx = {k_q, 1'b0} + 5'h01;
  assign hi_idx = {k_q, 1'b0} + 5'h02;
  assign lo_lim = i_range_table[lo_idx];
  assign hi_lim = i_range_table[hi_idx];
  assign cd     = i_req.word_a;

  // Inclusive inside, or wrap-around outside when limits are reversed
  always_comb begin
    if (lo_lim <= hi_lim) begin
      hit = (cd >= lo_lim) && (cd <= hi_lim);
    end else begin
      hit = (cd >= lo_lim) || (cd <= hi_lim);
    end
  end

  assign cmp_last = (state_q == bcd_alu_pkg::ST_CMP) && (k_q >= last_k);
  assign acc_d    = acc_q | (16'h0001 << k_q);

  ////////////////////////////////////////////////////////////////////////////
  // Compare sequencer: one range per cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q   <= bcd_alu_pkg::ST_IDLE;
      k_q       <= 4'h0;
      acc_q     <= bcd_alu_pkg::RESULT_RESET;
      cmp_err_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      unique case (state_q)
        bcd_alu_pkg::ST_IDLE: begin
          if (exec_idle && i_req.op == bcd_alu_pkg::OP_BCMP) begin
            state_q   <= bcd_alu_pkg::ST_CMP;
            k_q       <= 4'h0;
            acc_q     <= bcd_alu_pkg::RESULT_RESET;
            cmp_err_q <= i_indirect_fault;
            busy_q    <= 1'b1;
          end
        end
        bcd_alu_pkg::ST_CMP: begin
          if (hit) begin
            acc_q <= acc_d;
          end
          cmp_err_q <= cmp_err_q | i_indirect_fault;
          if (cmp_last) begin
            state_q <= bcd_alu_pkg::ST_IDLE;
            busy_q  <= 1'b0;
          end else begin
            k_q <= 4'(k_q + 4'h1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result word and flags
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      result_q <= bcd_alu_pkg::RESULT_RESET;
      flags_q  <= bcd_alu_pkg::FLAGS_RESET;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (exec_idle) begin
        unique case (i_req.op)
          bcd_alu_pkg::OP_CLC: begin
            flags_q.carry <= 1'b0;
            done_q        <= 1'b1;
          end
          bcd_alu_pkg::OP_ADD, bcd_alu_pkg::OP_SUB: begin
            done_q <= 1'b1;
            if (arith_err) begin
              flags_q.error <= 1'b1;
            end else begin
              result_q      <= sum;
              flags_q.carry <= is_sub ? ~sum_cout : sum_cout;
              flags_q.zero  <= sum == bcd_alu_pkg::ZERO_WORD;
              flags_q.error <= 1'b0;
            end
          end
          bcd_alu_pkg::OP_BCMP: begin
          end
        endcase
      end
      // Compare writes its result and error once, at its last range
      if (cmp_last) begin
        result_q      <= hit ? acc_d : acc_q;
        flags_q.error <= cmp_err_q | i_indirect_fault;
        done_q        <= 1'b1;
      end
    end
  end

  assign o_result = result_q;
  assign o_flags  = flags_q;
  assign o_busy   = busy_q;
  assign o_done   = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  int   ref_add;
  int   ref_sub;
  logic last_cmp_q;
  logic [3:0] last_n_q;
  logic [3:0] busy_cnt_q;

  assign ref_add = bcd_alu_pkg::bcd_to_bin(i_req.word_a)
                 + bcd_alu_pkg::bcd_to_bin(i_req.word_b) + int'(flags_q.carry);
  assign ref_sub = bcd_alu_pkg::DEC_MODULUS + bcd_alu_pkg::bcd_to_bin(i_req.word_a)
                 - bcd_alu_pkg::bcd_to_bin(i_req.word_b) - int'(flags_q.carry);

  // Remembers the size of the compare that just finished
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      last_cmp_q <= 1'b0;
      last_n_q   <= 4'h0;
    end else begin
      last_cmp_q <= cmp_last;
      last_n_q   <= last_k;
    end
  end

  // Counts the cycles a compare has been busy so far
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt_q <= 4'h0;
    end else begin
      busy_cnt_q <= busy_q ? 4'(busy_cnt_q + 4'h1) : 4'h0;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  AST_IDLE_HOLD: assert property (
    !busy_q && !i_exec_cond |=> $stable(o_result) && $stable(o_flags) && !o_done)
    else $error("state changed with execution condition off");

  AST_CLC: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_CLC |=> !o_flags.carry && o_done)
    else $error("clear carry left carry set");

  AST_ADD_RESULT: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_ADD && !arith_err
    |=> bcd_alu_pkg::bcd_to_bin(o_result) == $past(ref_add) % bcd_alu_pkg::DEC_MODULUS)
    else $error("add result wrong");

  AST_ADD_CARRY: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_ADD && !arith_err
    |=> o_flags.carry == ($past(ref_add) > bcd_alu_pkg::DEC_MAX))
    else $error("add carry wrong");

  AST_SUB_RESULT: assert property (
    exec_idle && is_sub && !arith_err
    |=> bcd_alu_pkg::bcd_to_bin(o_result) == $past(ref_sub) % bcd_alu_pkg::DEC_MODULUS)
    else $error("subtract result wrong");

  AST_SUB_CARRY: assert property (
    exec_idle && is_sub && !arith_err
    |=> o_flags.carry == ($past(ref_sub) < bcd_alu_pkg::DEC_MODULUS))
    else $error("subtract carry wrong");

  AST_ZERO: assert property (
    exec_idle && i_req.op inside {bcd_alu_pkg::OP_ADD, bcd_alu_pkg::OP_SUB} && !arith_err
    |=> o_flags.zero == (o_result == bcd_alu_pkg::ZERO_WORD))
    else $error("zero flag disagrees with result");

  AST_BCD_ERR: assert property (
    exec_idle && i_req.op inside {bcd_alu_pkg::OP_ADD, bcd_alu_pkg::OP_SUB} && arith_err
    |=> o_flags.error && $stable(o_result))
    else $error("bad operand not flagged");

  AST_CMP_UPPER: assert property (
    last_cmp_q |-> o_done && ((o_result >> last_n_q) >> 1) == bcd_alu_pkg::ZERO_WORD)
    else $error("compare bits above N not zero");

  AST_CMP_LEN: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_BCMP |=> o_busy ##1 (o_busy || o_done))
    else $error("compare sequence malformed");

  // Further arithmetic checks: zero flags against the decimal model, then error flags and clear carry
  AST_ADD_ZERO: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_ADD && !arith_err
    |=> o_flags.zero == ($past(ref_add) % bcd_alu_pkg::DEC_MODULUS == 0))
    else $error("add zero flag wrong");

  AST_SUB_ZERO: assert property (
    exec_idle && is_sub && !arith_err
    |=> o_flags.zero == ($past(ref_sub) % bcd_alu_pkg::DEC_MODULUS == 0))
    else $error("subtract zero flag wrong");

  AST_SUB_ERR: assert property (
    exec_idle && is_sub
    && !(bcd_alu_pkg::bcd_ok(i_req.word_a) && bcd_alu_pkg::bcd_ok(i_req.word_b))
    |=> o_flags.error && $stable(o_flags.carry) && $stable(o_flags.zero))
    else $error("subtract with bad digit not flagged");

  AST_FAULT_ERR: assert property (
    exec_idle && i_req.op inside {bcd_alu_pkg::OP_ADD, bcd_alu_pkg::OP_SUB} && i_indirect_fault
    |=> o_flags.error && $stable(o_result))
    else $error("addressing fault not flagged");

  AST_CLC_KEEP: assert property (
    exec_idle && i_req.op == bcd_alu_pkg::OP_CLC
    |=> $stable(o_result) && $stable(o_flags.zero) && $stable(o_flags.error))
    else $error("clear carry touched more than carry");

  // Further compare checks
  AST_CMP_HOLD: assert property (
    busy_q && !cmp_last |=> $stable(o_result) && $stable(o_flags) && !o_done)
    else $error("compare changed outputs before its last range");

  AST_CMP_CZ: assert property (
    cmp_last |=> $stable(o_flags.carry) && $stable(o_flags.zero))
    else $error("compare touched carry or zero");

  AST_CMP_ERR: assert property (
    cmp_last && i_indirect_fault |=> o_flags.error)
    else $error("fault during compare not flagged");

  AST_BUSY_BOUND: assert property (
    busy_q |-> busy_cnt_q <= 4'(bcd_alu_pkg::MAX_N))
    else $error("compare ran past its last range");

endmodule

/* core/bcd_alu_pkg.sv */
/*
  Shared constants, types and helper functions of the BCD compare/add/sub unit.
  Assumes operands are four packed BCD digits, least significant digit in 3:0.
*/
// Behaviour
// - Condition off: nothing changes; a running compare still completes and writes its result
// - N from base low digit, N+1 ranges
// - Range word pair: lower then upper limit
// - Lower below upper: bit k set inside
// - Lower above upper: bit k set outside
// - Compare reads live table values throughout
// - Indirect addressing fault sets error flag
// - Add: augend plus addend plus carry
// - Add carry set when sum exceeds 9999
// - Add error on non BCD operand
// - Zero flag follows add/sub result
// - Subtract: minuend less subtrahend less carry
// - Subtract as 10000 plus minuend, complement
// - Subtract carry when minuend below subtrahend+carry
// - Subtract error on non BCD operand
package bcd_alu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int WORD_W      = 16;
  localparam int DIGITS      = 4;
  localparam int DIGIT_W     = 4;
  localparam int MAX_N       = 9;
  localparam int TABLE_WORDS = 2 * MAX_N + 3;
  localparam int IDX_W       = 5;
  localparam int K_W         = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and values
  localparam int SIZE_DIGIT_LSB          = 0;
  localparam logic [3:0] MAX_BCD_DIGIT   = 4'h9;
  localparam logic [3:0] MAX_N_DIGIT     = 4'h9;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam int DEC_MODULUS             = 10000;
  localparam int DEC_MAX                 = 9999;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    OP_BCMP,
    OP_CLC,
    OP_ADD,
    OP_SUB
  } op_code_t;

  typedef enum {
    ST_IDLE,
    ST_CMP
  } state_t;

  typedef struct packed {
    op_code_t          op;
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
  } op_req_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic error;
  } flags_t;

  typedef logic [TABLE_WORDS-1:0][WORD_W-1:0] range_table_t;

  localparam flags_t FLAGS_RESET = '{carry: 1'b0, zero: 1'b0, error: 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic bcd_ok(input logic [WORD_W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (w[i*DIGIT_W +: DIGIT_W] > MAX_BCD_DIGIT) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic int bcd_to_bin(input logic [WORD_W-1:0] w);
    int v;
    v = 0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      v = v * 10 + int'(w[i*DIGIT_W +: DIGIT_W]);
    end
    return v;
  endfunction

endpackage

/* core/bcd_word_adder.sv */
/*
  Ripple BCD adder over a word of packed digits, with optional nines
  complement of the second operand for subtraction.
  Assumes both operands hold valid BCD digits; purely combinational.
*/
`timescale 1ns/1ps
module bcd_word_adder #(
  parameter int DIGITS = 4
) (
  // Operands
  input  wire logic [4*DIGITS-1:0] i_a,
  input  wire logic [4*DIGITS-1:0] i_b,
  input  wire logic                i_sub,
  input  wire logic                i_cin,
  // Result
  output logic      [4*DIGITS-1:0] o_sum,
  output logic                     o_cout
);

  logic [DIGITS:0] carry;

  assign carry[0] = i_cin;
  assign o_cout   = carry[DIGITS];

  // One decimal digit per stage, adjusted by six past nine
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    logic [3:0] b_d;
    logic [4:0] raw;
    logic       adj;
    assign b_d = i_sub ? 4'(4'h9 - i_b[4*g +: 4]) : i_b[4*g +: 4]; // Nines complement
    assign raw = {1'b0, i_a[4*g +: 4]} + {1'b0, b_d} + {4'h0, carry[g]};
    assign adj = raw > 5'h09;
    assign o_sum[4*g +: 4] = adj ? 4'(raw + 5'h06) : raw[3:0];
    assign carry[g+1] = adj;
  end

endmodule

/* dv/bcd_compare_add_sub_unit_tb.sv */
/*
  Self-checking bench of the BCD compare/add/sub unit: ops but the last compare are issued
  through a request task and results and flags are compared with hand-worked values.
  Assumes the unit answers with a one-cycle done pulse per accepted op.
*/
`timescale 1ns/1ps
module bcd_compare_add_sub_unit_tb;
  // Clock and reset
  logic                           i_clk_sys;
  logic                           i_rstn;
  // Operation request
  logic                           i_exec_cond;
  bcd_alu_pkg::op_req_t           i_req;
  logic                           i_indirect_fault;
  bcd_alu_pkg::range_table_t      i_range_table;
  // Results
  logic [bcd_alu_pkg::WORD_W-1:0] o_result;
  bcd_alu_pkg::flags_t            o_flags;
  logic                           o_busy;
  logic                           o_done;
  int                             fail_count;
  int                             n_compared;

  bcd_compare_add_sub_unit dut_u (
    .i_clk_sys        (i_clk_sys),
    .i_rstn           (i_rstn),
    .i_exec_cond      (i_exec_cond),
    .i_req            (i_req),
    .i_indirect_fault (i_indirect_fault),
    .i_range_table    (i_range_table),
    .o_result         (o_result),
    .o_flags          (o_flags),
    .o_busy           (o_busy),
    .o_done           (o_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period
  initial i_clk_sys = 1'b0;
  always #50 i_clk_sys = ~i_clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare a word
  task automatic cmp16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Compare the flag group
  task automatic cmp_fl(input logic c, input logic z, input logic e);
    bcd_alu_pkg::flags_t exp;
    exp = '{carry: c, zero: z, error: e};
    n_compared++;
    if (o_flags !== exp) begin
      fail_count++;
      $display("MISMATCH flags expected %b seen %b", exp, o_flags);
    end
  endtask

  // Issue one op for one taken edge, then wait for done under a bound
  task automatic do_op(input bcd_alu_pkg::op_code_t op, input logic [15:0] a,
                       input logic [15:0] b, input logic flt);
    bit seen;
    seen = 0;
    i_req = '{op: op, word_a: a, word_b: b};
    i_indirect_fault = flt;
    i_exec_cond = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_exec_cond = 1'b0;
    for (int i = 0; i < 15 && !seen; i++) begin
      if (o_done === 1'b1) begin
        seen = 1;
      end else begin
        @(posedge i_clk_sys);
        #1;
      end
    end
    i_indirect_fault = 1'b0;
    if (!seen) begin
      fail_count++;
      $display("MISMATCH done expected 1 seen 0");
    end
    // A spare edge keeps two requests out of one time step
    @(posedge i_clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial begin
    #(3000 * 100);
    fail_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] cmp_tab [4][2];
    fail_count = 0;
    n_compared = 0;
    i_rstn = 1'b0;
    i_exec_cond = 1'b0;
    i_req = '0;
    i_indirect_fault = 1'b0;
    i_range_table = '0;
    cmp_tab = '{'{16'h0015, 16'h0003}, '{16'h0040, 16'h0000},
                '{16'h0020, 16'h0003}, '{16'h0050, 16'h0002}};
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_rstn = 1'b1;
    cmp16("result", 16'h0000, o_result);
    cmp_fl(1'b0, 1'b0, 1'b0);
    // Add with overflow, carry in, and the 9999 boundary
    do_op(bcd_alu_pkg::OP_ADD, 16'h9999, 16'h0001, 1'b0);
    cmp16("result", 16'h0000, o_result);
    cmp_fl(1'b1, 1'b1, 1'b0);
    do_op(bcd_alu_pkg::OP_ADD, 16'h0001, 16'h0002, 1'b0);
    cmp16("result", 16'h0004, o_result);
    do_op(bcd_alu_pkg::OP_ADD, 16'h5000, 16'h4999, 1'b0);
    cmp16("result", 16'h9999, o_result);
    cmp_fl(1'b0, 1'b0, 1'b0);
    do_op(bcd_alu_pkg::OP_ADD, 16'h9999, 16'h9999, 1'b0);
    cmp16("result", 16'h9998, o_result);
    cmp_fl(1'b1, 1'b0, 1'b0);
    // Condition off: a subtract is presented but nothing may move
    i_req = '{op: bcd_alu_pkg::OP_SUB, word_a: 16'h0000, word_b: 16'h0001};
    repeat (3) begin
      @(posedge i_clk_sys);
      #1;
      cmp16("done", 16'h0000, {15'h0000, o_done});
    end
    cmp16("result", 16'h9998, o_result);
    cmp_fl(1'b1, 1'b0, 1'b0);
    // Clear carry touches only the carry
    do_op(bcd_alu_pkg::OP_CLC, 16'h0000, 16'h0000, 1'b0);
    cmp16("result", 16'h9998, o_result);
    cmp_fl(1'b0, 1'b0, 1'b0);
    // Subtract: complement, carry in and borrow out
    do_op(bcd_alu_pkg::OP_SUB, 16'h0089, 16'h0100, 1'b0);
    cmp16("result", 16'h9989, o_result);
    cmp_fl(1'b1, 1'b0, 1'b0);
    do_op(bcd_alu_pkg::OP_SUB, 16'h0000, 16'h9989, 1'b0);
    cmp16("result", 16'h0010, o_result);
    do_op(bcd_alu_pkg::OP_CLC, 16'h0000, 16'h0000, 1'b0);
    do_op(bcd_alu_pkg::OP_SUB, 16'h0000, 16'h9989, 1'b0);
    cmp16("result", 16'h0011, o_result);
    cmp_fl(1'b1, 1'b0, 1'b0);
    do_op(bcd_alu_pkg::OP_SUB, 16'h0011, 16'h0010, 1'b0);
    cmp16("result", 16'h0000, o_result);
    cmp_fl(1'b0, 1'b1, 1'b0);
    // Operand and addressing errors leave the result alone
    do_op(bcd_alu_pkg::OP_ADD, 16'h00A0, 16'h0001, 1'b0);
    cmp_fl(1'b0, 1'b1, 1'b1);
    do_op(bcd_alu_pkg::OP_SUB, 16'h0001, 16'h0001, 1'b0);
    cmp_fl(1'b0, 1'b1, 1'b0);
    do_op(bcd_alu_pkg::OP_SUB, 16'h1234, 16'hF000, 1'b0);
    cmp_fl(1'b0, 1'b1, 1'b1);
    do_op(bcd_alu_pkg::OP_ADD, 16'h0001, 16'h0001, 1'b1);
    cmp16("result", 16'h0000, o_result);
    cmp_fl(1'b0, 1'b1, 1'b1);
    // Block compare, N=1: normal and reversed range, bit 2 bait
    i_range_table[0] = 16'h0001;
    i_range_table[1] = 16'h0010;
    i_range_table[2] = 16'h0020;
    i_range_table[3] = 16'h0050;
    i_range_table[4] = 16'h0030;
    i_range_table[6] = 16'h9999;
    foreach (cmp_tab[i]) begin
      do_op(bcd_alu_pkg::OP_BCMP, cmp_tab[i][0], 16'h0000, 1'b0);
      cmp16("compare", cmp_tab[i][1], o_result);
      cmp_fl(1'b0, 1'b1, 1'b0);
    end
    // N=2 with an addressing fault during the run
    i_range_table[0] = 16'h0002;
    do_op(bcd_alu_pkg::OP_BCMP, 16'h0040, 16'h0000, 1'b1);
    cmp16("compare", 16'h0004, o_result);
    cmp_fl(1'b0, 1'b1, 1'b1);
    // N=9: every range spans the whole scale
    i_range_table[0] = 16'h0009;
    for (int k = 0; k < 10; k++) begin
      i_range_table[2*k+1] = 16'h0000;
      i_range_table[2*k+2] = 16'h9999;
    end
    do_op(bcd_alu_pkg::OP_BCMP, 16'h0000, 16'h0000, 1'b0);
    cmp16("compare", 16'h03FF, o_result);
    cmp_fl(1'b0, 1'b1, 1'b0);
    // Size and limits changed while the compare runs: N 1 to 2, range 1 moved
    i_range_table[0] = 16'h0001;
    i_req = '{op: bcd_alu_pkg::OP_BCMP, word_a: 16'h0000, word_b: 16'h0000};
    i_exec_cond = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_exec_cond = 1'b0;
    i_range_table[0] = 16'h0002;
    i_range_table[3] = 16'h0050;
    i_range_table[4] = 16'h0060;
    cmp16("busy", 16'h0001, {15'h0000, o_busy});
    repeat (3) @(posedge i_clk_sys);
    #1;
    cmp16("done", 16'h0001, {15'h0000, o_done});
    cmp16("busy", 16'h0000, {15'h0000, o_busy});
    cmp16("compare", 16'h0005, o_result);
    cmp_fl(1'b0, 1'b1, 1'b0);
    end_sim();
  end
endmodule
